/* inc/mac_pkg.sv */
// Purpose: shared constants for the snooping multiply-accumulate pair
// Assumes: register bus carries word indices, memory bus carries 16-bit byte addresses
// Notes: result words have no reset value at all
package mac_pkg;
   // ----------------------------------------
   // Device register indices
   // ----------------------------------------
   localparam logic [3:0] IDX_CONTROL = 4'h0;
   localparam logic [3:0] IDX_BASE = 4'h1;
   localparam logic [3:0] IDX_MULT_LOW = 4'h2;
   localparam logic [3:0] IDX_MCAND_LOW = 4'h3;
   localparam logic [3:0] IDX_HOLD_A = 4'h4;
   localparam logic [3:0] IDX_HOLD_B = 4'h5;
   localparam logic [3:0] IDX_HOLD_C = 4'h6;
   localparam logic [3:0] IDX_DIRECT_MULT = 4'h7;
   localparam logic [3:0] IDX_DIRECT_MCAND = 4'h8;
   localparam logic [3:0] IDX_EXT = 4'h9;
   localparam logic [3:0] IDX_HIGH = 4'ha;
   localparam logic [3:0] IDX_LOW = 4'hb;
   // ----------------------------------------
   // Control field positions and values
   // ----------------------------------------
   localparam int BIT_ZERO_EN = 7;
   localparam int BIT_STEAL_EN = 6;
   localparam int BIT_SIGN = 2;
   localparam int BIT_PRODUCT = 1;
   localparam int BIT_ACCUM = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_FIXED_ONES = 8'h38;
   localparam logic [7:0] CONTROL_WR_MASK = 8'hc7;
   localparam logic [15:0] WRITE_ONLY_READ = 16'hffff;
   localparam logic [15:0] SNOOP_STEP_B = 16'h0002;
   localparam logic [15:0] SNOOP_STEP_C = 16'h0004;
   // ----------------------------------------
   // Controller APB map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_WDATA = 8'h04;
   localparam logic [7:0] APB_STATUS = 8'h08;
   localparam logic [7:0] APB_RDATA = 8'h0c;
   localparam int CMD_MEM_BIT = 16;
   localparam int CMD_WRITE_BIT = 17;
endpackage

/* inc/mac_link_if.sv */
// Purpose: connection between CPU-side controller and the multiply-accumulate unit
// Assumes: one clock, all signals synchronous to pclk
// Notes: reg_req is held until reg_ack; mem_valid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface mac_link_if;
   logic reg_req;
   logic reg_write;
   logic [3:0] reg_idx;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic reg_ack;
   logic mem_valid;
   logic mem_write;
   logic [15:0] mem_addr;
   logic [15:0] mem_data;
   modport device (input reg_req, reg_write, reg_idx, reg_wdata, mem_valid, mem_write,
      mem_addr, mem_data, output reg_rdata, reg_ack);
   modport host (output reg_req, reg_write, reg_idx, reg_wdata, mem_valid, mem_write,
      mem_addr, mem_data, input reg_rdata, reg_ack);
endinterface
`default_nettype wire

/* hw/mac_unit.sv */
// Purpose: 16x16 multiplier with 42-bit signed and 32-bit saturating unsigned accumulate, direct and snooped operands
// Assumes: controller keeps register request until acknowledge
// Notes: result words hold their value across reset
`timescale 1ns/1ps
`default_nettype none
module mac_unit
   import mac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   mac_link_if.device link
);
   import mac_pkg::*;

   // ----------------------------------------
   // Configuration and operand storage
   // ----------------------------------------
   logic [7:0] control;
   logic [7:0] base_upper;
   logic [7:0] mult_lower;
   logic [7:0] mcand_lower;
   logic [15:0] hold [3];
   logic [15:0] direct_mult;
   logic [15:0] result_extension_word;
   logic [15:0] result_high_word;
   logic [15:0] result_low_word;
   logic [15:0] rdata;
   logic ack;

   // Register access decode; one action per held request
   wire access = link.reg_req && !ack;
   wire wr = access && link.reg_write;
   wire wr_control = wr && (link.reg_idx == IDX_CONTROL);
   wire wr_base = wr && (link.reg_idx == IDX_BASE);
   wire wr_mult_low = wr && (link.reg_idx == IDX_MULT_LOW);
   wire wr_mcand_low = wr && (link.reg_idx == IDX_MCAND_LOW);
   wire wr_direct_mult = wr && (link.reg_idx == IDX_DIRECT_MULT);
   wire wr_direct_mcand = wr && (link.reg_idx == IDX_DIRECT_MCAND);
   wire wr_ext = wr && (link.reg_idx == IDX_EXT);
   wire wr_high = wr && (link.reg_idx == IDX_HIGH);
   wire wr_low = wr && (link.reg_idx == IDX_LOW);
   wire wr_result = wr_ext || wr_high || wr_low;
   wire zero_en = control[BIT_ZERO_EN];

   // ----------------------------------------
   // Snoop address compare
   // ----------------------------------------
   // Compare only; the CPU access itself is never held or changed
   wire steal_en = control[BIT_STEAL_EN];
   wire snoop = link.mem_valid && steal_en;
   wire [15:0] mult_addr = {base_upper, mult_lower};
   wire [15:0] mcand_addr = {base_upper, mcand_lower};
   wire [2:0] mult_hit;
   wire [2:0] mcand_hit;
   wire [15:0] step [3];
   assign step[0] = 16'h0000;
   assign step[1] = SNOOP_STEP_B;
   assign step[2] = SNOOP_STEP_C;

   // Per-register load paths: direct write and snoop capture
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_hold
         assign mult_hit[gi] = snoop && (link.mem_addr == mult_addr + step[gi]);
         assign mcand_hit[gi] = snoop && (link.mem_addr == mcand_addr + step[gi]);
         wire direct_hit = wr && (link.reg_idx == IDX_HOLD_A + 4'(gi));
         // Direct write wins a same-cycle collision; both paths stay independent
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               hold[gi] <= 16'h0000;
            else if (direct_hit)
               hold[gi] <= link.reg_wdata;
            else if (mult_hit[gi])
               hold[gi] <= link.mem_data;
         end
      end
   endgenerate

   // ----------------------------------------
   // Operand selection and start
   // ----------------------------------------
   // Direct multiplicand port beats a snoop hit in the same cycle
   wire start_direct = wr_direct_mcand;
   wire start_snoop = |mcand_hit;
   wire mult_load = |mult_hit;
   wire start = start_direct || start_snoop;
   wire [15:0] snoop_mult = mcand_hit[0] ? hold[0] :
      (mcand_hit[1] ? hold[1] : hold[2]);
   wire [15:0] op_mult = start_direct ? direct_mult : snoop_mult;
   wire [15:0] op_mcand = start_direct ? link.reg_wdata : link.mem_data;

   // ----------------------------------------
   // Arithmetic
   // ----------------------------------------
   wire sign_sel = control[BIT_SIGN];
   wire product_sel = control[BIT_PRODUCT];
   wire accum_sel = control[BIT_ACCUM];
   wire [31:0] prod_u = op_mult * op_mcand;
   wire signed [31:0] prod_s = $signed(op_mult) * $signed(op_mcand);
   wire [41:0] prod42 = sign_sel ? {{10{prod_s[31]}}, prod_s} : {10'h000, prod_u};
   wire [41:0] acc42 = {result_extension_word[9:0], result_high_word, result_low_word};
   wire [41:0] sum42 = acc42 + prod42;
   wire [32:0] sum33 = {1'b0, result_high_word, result_low_word} + {1'b0, prod_u};
   wire sat_ovf = sum33[32];
   wire [31:0] sat32 = sat_ovf ? 32'hffffffff : sum33[31:0];
   wire do_product = start && product_sel && !accum_sel;
   wire do_accum = start && accum_sel && !product_sel;
   wire do_sat = do_accum && !sign_sel;
   wire do_wide = do_accum && sign_sel;

   // Next values of the result words; an operation outranks a software write
   logic [15:0] next_ext;
   logic [15:0] next_high;
   logic [15:0] next_low;
   always_comb
   begin
      next_ext = result_extension_word;
      next_high = result_high_word;
      next_low = result_low_word;
      if (do_product)
      begin
         next_ext = {{6{prod42[41]}}, prod42[41:32]};
         next_high = prod42[31:16];
         next_low = prod42[15:0];
      end
      else if (do_wide)
      begin
         next_ext = {{6{sum42[41]}}, sum42[41:32]};
         next_high = sum42[31:16];
         next_low = sum42[15:0];
      end
      else if (do_sat)
      begin
         // Overflow flag is sticky until software, a product or a signed accumulate rewrites the extension word
         next_ext = {result_extension_word[15:1], result_extension_word[0] | sat_ovf};
         next_high = sat32[31:16];
         next_low = sat32[15:0];
      end
      else if (wr_result && zero_en)
      begin
         next_ext = 16'h0000;
         next_high = 16'h0000;
         next_low = 16'h0000;
      end
      else
      begin
         if (wr_ext)
            next_ext = link.reg_wdata;
         if (wr_high)
            next_high = link.reg_wdata;
         if (wr_low)
            next_low = link.reg_wdata;
      end
   end

   // Result words carry no reset so a reset keeps accumulated work
   always_ff @(posedge pclk)
   begin
      result_extension_word <= next_ext;
      result_high_word <= next_high;
      result_low_word <= next_low;
   end

   // ----------------------------------------
   // Control, address and direct multiplier registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control <= CONTROL_RESET;
         base_upper <= 8'h00;
         mult_lower <= 8'h00;
         mcand_lower <= 8'h00;
         direct_mult <= 16'h0000;
      end
      else
      begin
         if (wr_control)
            control <= link.reg_wdata[7:0] & CONTROL_WR_MASK;
         if (wr_base)
            base_upper <= link.reg_wdata[7:0];
         if (wr_mult_low)
            mult_lower <= link.reg_wdata[7:0];
         if (wr_mcand_low)
            mcand_lower <= link.reg_wdata[7:0];
         // A snooped multiplier also feeds the direct path for the next start
         if (wr_direct_mult)
            direct_mult <= link.reg_wdata;
         else if (mult_load)
            direct_mult <= link.mem_data;
      end
   end

   // ----------------------------------------
   // Read-back and acknowledge
   // ----------------------------------------
   logic [15:0] read_mux;
   always_comb
   begin
      case (link.reg_idx)
         IDX_CONTROL: read_mux = {8'h00, control | CONTROL_FIXED_ONES};
         IDX_BASE: read_mux = {8'h00, base_upper};
         IDX_MULT_LOW: read_mux = {8'h00, mult_lower};
         IDX_MCAND_LOW: read_mux = {8'h00, mcand_lower};
         IDX_HOLD_A: read_mux = hold[0];
         IDX_HOLD_B: read_mux = hold[1];
         IDX_HOLD_C: read_mux = hold[2];
         IDX_DIRECT_MULT: read_mux = WRITE_ONLY_READ;
         IDX_DIRECT_MCAND: read_mux = WRITE_ONLY_READ;
         IDX_EXT: read_mux = result_extension_word;
         IDX_HIGH: read_mux = result_high_word;
         IDX_LOW: read_mux = result_low_word;
         default: read_mux = 16'h0000;
      endcase
   end

   // Answer one cycle after the request, data from a flop; reads never clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack <= 1'b0;
         rdata <= 16'h0000;
      end
      else
      begin
         ack <= access;
         if (access && !link.reg_write)
            rdata <= read_mux;
      end
   end

   assign link.reg_ack = ack;
   assign link.reg_rdata = rdata;
endmodule
`default_nettype wire

/* hw/cpu_side.sv */
// Purpose: CPU-side controller issuing register and memory accesses from APB
// Assumes: software sequences accesses in the order the unit expects
// Notes: memory data word is the controller's own write-data value
`timescale 1ns/1ps
`default_nettype none
module cpu_side
   import mac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   mac_link_if.host link
);
   import mac_pkg::*;

   typedef enum logic [1:0] {IDLE = 2'b00, REG_WAIT = 2'b01, MEM_PULSE = 2'b10} state_t;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   state_t state;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] addr;
   logic is_write;
   wire apb_wr = psel && penable && pwrite;
   wire busy = (state != IDLE);
   // A command while busy is dropped; software polls status first
   wire cmd_go = apb_wr && (paddr == APB_CMD) && !busy;
   wire wr_wdata = apb_wr && (paddr == APB_WDATA);
   wire cmd_mem = pwdata[CMD_MEM_BIT];

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = (paddr == APB_STATUS) ? {31'h0, busy} :
      ((paddr == APB_RDATA) ? {16'h0000, rdata} :
      ((paddr == APB_WDATA) ? {16'h0000, wdata} : 32'h0));

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   // One access at a time keeps software order on the link
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= IDLE;
         addr <= 16'h0000;
         is_write <= 1'b0;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
      end
      else
      begin
         if (wr_wdata)
            wdata <= pwdata[15:0]; // Word-wide only
         case (state)
            IDLE:
               if (cmd_go)
               begin
                  addr <= pwdata[15:0];
                  is_write <= pwdata[CMD_WRITE_BIT];
                  state <= cmd_mem ? MEM_PULSE : REG_WAIT;
               end
            REG_WAIT:
               if (link.reg_ack)
               begin
                  if (!is_write)
                     rdata <= link.reg_rdata;
                  state <= IDLE;
               end
            MEM_PULSE:
               state <= IDLE;
            default:
               state <= IDLE;
         endcase
      end
   end

   // Link drive; results must be initialised by software before accumulating
   assign link.reg_req = (state == REG_WAIT);
   assign link.reg_write = is_write;
   assign link.reg_idx = addr[3:0];
   assign link.reg_wdata = wdata;
   assign link.mem_valid = (state == MEM_PULSE);
   assign link.mem_write = is_write;
   assign link.mem_addr = addr;
   assign link.mem_data = wdata;
endmodule
`default_nettype wire

/* sim/mac_props.sv */
// Purpose: link checks for the multiply-accumulate pair
// Assumes: single clock, one register request at a time
// Notes: keeps a tiny shadow of control and of a fresh clear
`timescale 1ns/1ps
`default_nettype none
module mac_props
   import mac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reg_req,
   input wire logic reg_write,
   input wire logic [3:0] reg_idx,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic mem_valid
);
   import mac_pkg::*;

   // ----------------------------------------
   // Shadow of control and of a fresh clear
   // ----------------------------------------
   logic [7:0] ctrl;
   logic zeroed;
   wire take = reg_req && !reg_ack;
   wire wr = take && reg_write;
   wire rd = take && !reg_write;
   wire hit_res = reg_idx >= IDX_EXT && reg_idx <= IDX_LOW;
   wire clear = wr && hit_res && ctrl[BIT_ZERO_EN];

   // Any write or snoop may move results, so the clear mark is dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= CONTROL_RESET;
         zeroed <= 1'b0;
      end
      else
      begin
         if (wr && reg_idx == IDX_CONTROL)
            ctrl <= reg_wdata[7:0] & CONTROL_WR_MASK;
         zeroed <= clear || (zeroed && !wr && !mem_valid);
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ack_cause: assert property (reg_ack |-> $past(take))
      else $error("acknowledge without a taken request");
   a_ack_pulse: assert property (take |=> reg_ack ##1 !reg_ack)
      else $error("acknowledge is not a single cycle");
   a_rdata_stands: assert property (!rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_ports_ones: assert property (
      rd && (reg_idx == IDX_DIRECT_MULT || reg_idx == IDX_DIRECT_MCAND)
      |=> reg_rdata == WRITE_ONLY_READ) else $error("write-only port read wrong");
   a_unmapped_zero: assert property (rd && reg_idx > IDX_LOW |=> reg_rdata == 16'h0000)
      else $error("unmapped index read not zero");
   a_ctrl_read: assert property (
      rd && reg_idx == IDX_CONTROL
      |=> reg_rdata == {8'h00, $past(ctrl) | CONTROL_FIXED_ONES})
      else $error("control readback wrong");
   a_zero_all: assert property (rd && hit_res && zeroed |=> reg_rdata == 16'h0000)
      else $error("result word not zero after clear");
   a_snoop_no_ack: assert property (mem_valid && !reg_req |=> !reg_ack)
      else $error("snoop produced an acknowledge");
endmodule
`default_nettype wire

/* sim/bus_snooping_multiply_accumulate_tb_top.sv */
// Purpose: drives the controller over APB and checks the unit's results
// Assumes: one link command at a time, busy polled before the next
// Notes: expectations come from plain arithmetic in this file
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end
module bus_snooping_multiply_accumulate_tb_top;
   import mac_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [47:0] got, ex;
   logic [15:0] q;
   int fails, samples_checked, cycles;

   mac_link_if link ();
   mac_unit mac_unit_inst (.pclk(pclk), .presetn(presetn), .link(link));
   cpu_side cpu_side_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   mac_props mac_props_inst (.pclk(pclk), .presetn(presetn), .reg_req(link.reg_req),
      .reg_write(link.reg_write), .reg_idx(link.reg_idx), .reg_wdata(link.reg_wdata),
      .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .mem_valid(link.mem_valid));

   // ----------------------------------------
   // Clock, hang guard and verdict
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Whole sequence needs under two thousand cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   // Waits an edge first, so psel never changes twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Data word before command, then poll busy so requests never overlap
   task automatic issue(input logic [17:0] cmd, input logic [15:0] d);
      logic [31:0] r;
      apb(1'b1, APB_WDATA, {16'h0000, d}, r);
      apb(1'b1, APB_CMD, {14'h0000, cmd}, r);
      do
         apb(1'b0, APB_STATUS, 32'h0, r);
      while (r[0] !== 1'b0);
      apb(1'b0, APB_RDATA, 32'h0, r);
      q = r[15:0];
   endtask

   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      issue({2'b10, 12'h000, i}, d);
   endtask

   task automatic rd(input logic [3:0] i);
      issue({2'b00, 12'h000, i}, 16'h0000);
   endtask

   task automatic mem(input logic w, input logic [15:0] a, input logic [15:0] d);
      issue({w, 1'b1, a}, d);
   endtask

   task automatic rres();
      rd(IDX_EXT);
      got[47:32] = q;
      rd(IDX_HIGH);
      got[31:16] = q;
      rd(IDX_LOW);
      got[15:0] = q;
   endtask

   task automatic preset(input logic [15:0] h, input logic [15:0] l);
      wr(IDX_CONTROL, 16'h0080);
      wr(IDX_EXT, 16'h1234);
      wr(IDX_CONTROL, 16'h0000);
      wr(IDX_HIGH, h);
      wr(IDX_LOW, l);
   endtask

   task automatic op(input logic [15:0] c, input logic [15:0] m, input logic [15:0] n);
      wr(IDX_CONTROL, c);
      wr(IDX_DIRECT_MULT, m);
      wr(IDX_DIRECT_MCAND, n);
      rres();
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_CONTROL);
      `chk(q, 16'h0038)
      rd(4'hc);
      `chk(q, 16'h0000)
      `chk(pslverr, 1'b0)
      for (int i = 7; i < 9; i++)
      begin
         rd(4'(i));
         `chk(q, WRITE_ONLY_READ)
      end
      // Clear works on any result word; other accesses leave results alone
      wr(IDX_CONTROL, 16'h0080);
      wr(IDX_HIGH, 16'h5555);
      rres();
      `chk(got, 48'h0)
      preset(16'h0001, 16'h0002);
      wr(IDX_CONTROL, 16'h0080);
      wr(IDX_BASE, 16'h00ee);
      rres();
      `chk(got, 48'h0000_0001_0002)
      wr(IDX_LOW, 16'h9999);
      rres();
      `chk(got, 48'h0)
      rd(IDX_CONTROL);
      `chk(q, 16'h00b8)
      // Negative signed product must fill the extension word with sign
      op(16'h0006, 16'hffff, 16'h0001);
      `chk(got, 48'hffff_ffff_ffff)
      // Unsigned then signed product of the same operands
      for (int i = 0; i < 2; i++)
      begin
         op(i == 1 ? 16'h0006 : 16'h0002, 16'haaaa, 16'hbbbb);
         if (i == 1)
            ex = $signed(16'haaaa) * $signed(16'hbbbb);
         else
            ex = 48'haaaa * 48'hbbbb;
         `chk(got, ex)
      end
      op(16'h0003, 16'haaaa, 16'h0005);
      `chk(got, ex)
      preset(16'h0000, 16'hcccc);
      op(16'h0005, 16'haaaa, 16'hbbbb);
      `chk(got, ex + 48'hcccc)
      preset(16'hffff, 16'hfffe);
      op(16'h0001, 16'h0002, 16'h0002);
      `chk(got, 48'h0001_ffff_ffff)
      // Steal disabled first, so this capture must not happen
      wr(IDX_BASE, 16'h00ee);
      wr(IDX_MULT_LOW, 16'h0080);
      wr(IDX_CONTROL, 16'h0000);
      mem(1'b1, 16'hee80, 16'h1111);
      rd(IDX_HOLD_A);
      `chk(q, 16'h0000)
      wr(IDX_CONTROL, 16'h0040);
      for (int i = 0; i < 3; i++)
      begin
         mem(1'(i), 16'hee80 + 16'(2 * i), 16'h1111 * 16'(i + 1));
         rd(IDX_HOLD_A + 4'(i));
         `chk(q, 16'h1111 * 16'(i + 1))
      end
      wr(IDX_HOLD_B, 16'h4444);
      rd(IDX_HOLD_B);
      `chk(q, 16'h4444)
      // Snooped multiplier, then the direct multiplicand at once
      preset(16'h0000, 16'hcccc);
      wr(IDX_CONTROL, 16'h0041);
      mem(1'b0, 16'hee80, 16'h0003);
      wr(IDX_DIRECT_MCAND, 16'hbbbb);
      rres();
      `chk(got, 48'h0000_0002_fffd)
      wr(IDX_MCAND_LOW, 16'h00a0);
      wr(IDX_CONTROL, 16'h0042);
      mem(1'b0, 16'heea2, 16'h0003);
      rres();
      `chk(got, 48'h0000_0000_cccc)
      // Second reset: results survive it, control does not
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rres();
      `chk(got, 48'h0000_0000_cccc)
      rd(IDX_CONTROL);
      `chk(q, 16'h0038)
      finish_test();
   end
endmodule
`default_nettype wire
